/* File: rtl/scutr_top.sv */
// Purpose: System control registers: trace routing, identification, reset control
// Assumes: APB slave, 32-bit data, one clock
// Notes: Contract
// Contract
// - Trace enable bit 0 turns trace output on; zero keeps it off.
// - Source field bits 2:1 route processor (00) or coprocessor (01) trace.
// - Trace register bits 31:3 read zero; software writes zeros.
// - Maker id: department bits 4:0, maker code 15:5, upper half zero.
// - Chip id: revision bits 7:0, part number 15:8, upper half zero.
// - Redesign id: index bits 2:0, laser fix flag bit 15.
// - Registers decoded at fixed offsets 0x10, 0x14, 0x54 and 0x70 onward by four.
// - Configuration pins sampled in power-on reset, latched at its end.
// - Writing the reset request register starts a software reset.
// - Watchdog fault raises NMI, then resets after a time-out.
// - Pin reset during deep sleep is recorded as wake-up reset.
// - Status register reports last reset type and boot configuration.
// - Open-drain reset pin: low input resets; device drives it low.
// - Software reset may apply software-chosen boot configuration.
// - Reset request write accepted only while init protection is unlocked.
`timescale 1ns/1ps
`include "scutr_cfg.svh"
module scutr_top import scutr_pkg::*; #(
  parameter int TRACE_W = 16,
  parameter int RST_HOLD_CYC = `SCUTR_RST_HOLD_CYC,
  parameter int WDT_TIMEOUT_CYC = `SCUTR_WDT_TIMEOUT_CYC,
  // Identification values below are arbitrary
  parameter logic [4:0] DEPARTMENT_NUMBER_ID = 5'h0A,
  parameter logic [10:0] MAKER_ID = 11'h2A5,
  parameter logic [7:0] PART_ID = 8'h3C,
  parameter logic [7:0] REV_ID = 8'h02,
  parameter logic [2:0] REDESIGN_ID = 3'h0,
  parameter logic LASER_FIX = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TRACE_W-1:0] cpu_trace,
  input wire logic [TRACE_W-1:0] cop_trace,
  output logic [TRACE_W-1:0] trace_port,
  input wire logic bidir_hard_reset_pin_in,
  output logic bidir_hard_reset_pin_out,
  output logic bidir_hard_reset_pin_oe_b,
  input wire logic deep_sleep,
  input wire logic init_unlock,
  input wire logic wdt_fault,
  output logic nmi_req,
  output logic sys_rst_b,
  output logic stm_rst_b,
  input wire logic [3:0] cfg_pins,
  input wire logic ocds_pin,
  input wire logic brk_pin,
  input wire logic [2:0] gp_boot_pins,
  output logic [3:0] boot_cfg,
  output logic boot_ocds,
  output logic boot_brk,
  output logic [2:0] boot_sel
);
  localparam int WW = $clog2(WDT_TIMEOUT_CYC + 1);
  logic rst_sync_b;
  logic seq_rst_b, pin_drive, seq_done, seq_idle, sw_req, wdt_req;
  scutr_cause_e cause;
  logic trc_en;
  logic [1:0] trc_sel;
  logic rr_stm, rr_x, rr_ext, rr_brk, rr_ocd, rr_boot;
  logic [2:0] rr_btcfg;
  logic [3:0] rr_swcfg;
  logic [4:0] st_cause;
  logic [2:0] st_low;
  logic [3:0] hw_cfg;
  logic hw_ocd, hw_brk;
  logic [2:0] hw_cfgp;
  logic wd_busy;
  logic [WW-1:0] wd_cnt;
  logic setup, hit, ro, err, wr_go;
  logic [31:0] rd_mux;
  // ****************************************
  // Reset release and sequencer
  // ****************************************
  scutr_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .rst_sync_b(rst_sync_b)
  );
  scutr_rst_seq #(.RST_HOLD_CYC(RST_HOLD_CYC)) u_seq (
    .clk(clk),
    .rst_b(rst_sync_b),
    .hw_req(!bidir_hard_reset_pin_in && !deep_sleep),
    .wake_req(!bidir_hard_reset_pin_in && deep_sleep),
    .wdt_req(wdt_req),
    .sw_req(sw_req),
    .sw_ext(rr_ext),
    .sys_rst_b(seq_rst_b),
    .pin_drive(pin_drive),
    .cause(cause),
    .done(seq_done),
    .idle(seq_idle)
  );
  // Reset outputs and open-drain pin drive
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sys_rst_b <= 1'b0;
      stm_rst_b <= 1'b0;
      bidir_hard_reset_pin_out <= 1'b0;
      bidir_hard_reset_pin_oe_b <= 1'b0;
    end else begin
      sys_rst_b <= seq_rst_b;
      stm_rst_b <= seq_rst_b || (cause == SCUTR_CAUSE_SFT && !rr_stm);
      bidir_hard_reset_pin_out <= 1'b0;
      bidir_hard_reset_pin_oe_b <= !pin_drive;
    end
  end
  // ****************************************
  // APB decode
  // ****************************************
  // Address hit, read-only and refusal checks
  always_comb begin
    setup = psel && !penable;
    hit = 1'b1;
    ro = 1'b0;
    case (paddr)
      `SCUTR_OFF_TRACE, `SCUTR_OFF_RST_REQ: ro = 1'b0;
      `SCUTR_OFF_MAKER, `SCUTR_OFF_CHIP, `SCUTR_OFF_REDESIGN, `SCUTR_OFF_RST_STAT: ro = 1'b1;
      default: hit = 1'b0;
    endcase
    err = !hit || (pwrite && ro) || (pwrite && paddr == `SCUTR_OFF_RST_REQ && !init_unlock);
    wr_go = psel && penable && pready && pwrite && !pslverr;
  end
  // Read data mux
  always_comb begin
    case (paddr)
      `SCUTR_OFF_TRACE: rd_mux = {29'h0000_0000, trc_sel, trc_en};
      `SCUTR_OFF_MAKER: rd_mux = {16'h0000, MAKER_ID, DEPARTMENT_NUMBER_ID};
      `SCUTR_OFF_CHIP: rd_mux = {16'h0000, PART_ID, REV_ID};
      `SCUTR_OFF_REDESIGN: rd_mux = {16'h0000, LASER_FIX, 12'h000, REDESIGN_ID};
      `SCUTR_OFF_RST_REQ: rd_mux = {7'h00, rr_boot, 3'h0, rr_brk, rr_ocd, rr_swcfg, rr_btcfg,
                                    9'h000, rr_ext, rr_x, rr_stm};
      `SCUTR_OFF_RST_STAT: rd_mux = {st_cause, 6'h00, hw_brk, hw_ocd, hw_cfg, hw_cfgp,
                                     9'h000, st_low};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // Zero-wait answer in the access cycle
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && err;
      prdata <= (setup && !pwrite && hit) ? rd_mux : 32'h0000_0000;
    end
  end
  // ****************************************
  // Trace control
  // ****************************************
  // Enable and source, cleared by any reset
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      trc_en <= 1'b0;
      trc_sel <= 2'h0;
    end else if (!seq_rst_b) begin
      {trc_sel, trc_en} <= `SCUTR_TRC_RESET;
    end else if (wr_go && paddr == `SCUTR_OFF_TRACE) begin
      trc_en <= pwdata[`SCUTR_TRC_EN_BIT];
      trc_sel <= pwdata[`SCUTR_TRC_SEL_LSB +: 2];
    end
  end
  // Trace port routing, reserved sources give zero
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      trace_port <= '0;
    end else if (!trc_en) begin
      trace_port <= '0;
    end else if (trc_sel == `SCUTR_SEL_CPU) begin
      trace_port <= cpu_trace;
    end else if (trc_sel == `SCUTR_SEL_COP) begin
      trace_port <= cop_trace;
    end else begin
      trace_port <= '0;
    end
  end
  // ****************************************
  // Software reset request
  // ****************************************
  // Fields survive the software reset they trigger
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      {rr_boot, rr_brk, rr_ocd, rr_swcfg, rr_btcfg, rr_ext, rr_x, rr_stm} <= `SCUTR_REQ_RESET;
      sw_req <= 1'b0;
    end else begin
      sw_req <= wr_go && paddr == `SCUTR_OFF_RST_REQ;
      if (wr_go && paddr == `SCUTR_OFF_RST_REQ) begin
        rr_stm <= pwdata[0];
        rr_x <= pwdata[1];
        rr_ext <= pwdata[2];
        rr_btcfg <= pwdata[14:12];
        rr_swcfg <= pwdata[18:15];
        rr_ocd <= pwdata[19];
        rr_brk <= pwdata[20];
        rr_boot <= pwdata[24];
      end
    end
  end
  // ****************************************
  // Watchdog escalation
  // ****************************************
  // NMI first, reset request after the time-out
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wd_busy <= 1'b0;
      wd_cnt <= '0;
      nmi_req <= 1'b0;
      wdt_req <= 1'b0;
    end else begin
      nmi_req <= 1'b0;
      wdt_req <= 1'b0;
      if (!wd_busy && wdt_fault && seq_rst_b) begin
        wd_busy <= 1'b1;
        wd_cnt <= '0;
        nmi_req <= 1'b1;
      end else if (wd_busy) begin
        wd_cnt <= wd_cnt + 1'b1;
        if (wd_cnt == WW'(WDT_TIMEOUT_CYC - 1)) begin
          wd_busy <= 1'b0;
          wdt_req <= 1'b1;
        end
      end
    end
  end
  // ****************************************
  // Reset status and boot configuration
  // ****************************************
  // Latch cause at the end of each sequence
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_cause <= 5'h00;
      st_low <= 3'h0;
    end else if (seq_done) begin
      st_cause <= cause;
      case (cause)
        SCUTR_CAUSE_PWO: st_low <= `SCUTR_LOW_POR;
        SCUTR_CAUSE_HD: st_low <= `SCUTR_LOW_HW;
        SCUTR_CAUSE_WDT: st_low <= `SCUTR_LOW_WDT;
        SCUTR_CAUSE_PWD: st_low <= `SCUTR_LOW_WAKE;
        SCUTR_CAUSE_SFT: st_low <= {rr_ext, rr_x, rr_stm};
        default: st_low <= 3'h0;
      endcase
    end
  end
  // Pins caught at the end of power-on reset only
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hw_cfg <= 4'h0;
      hw_ocd <= 1'b0;
      hw_brk <= 1'b0;
      hw_cfgp <= 3'h0;
    end else if (seq_done && cause == SCUTR_CAUSE_PWO) begin
      hw_cfg <= cfg_pins;
      hw_ocd <= ocds_pin;
      hw_brk <= brk_pin;
      hw_cfgp <= gp_boot_pins;
    end
  end
  // Applied boot configuration
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      boot_cfg <= 4'h0;
      boot_ocds <= 1'b0;
      boot_brk <= 1'b0;
      boot_sel <= 3'h0;
    end else if (seq_done && cause == SCUTR_CAUSE_PWO) begin
      {boot_cfg, boot_ocds, boot_brk, boot_sel} <= {cfg_pins, ocds_pin, brk_pin, gp_boot_pins};
    end else if (seq_done && cause == SCUTR_CAUSE_SFT && rr_boot) begin
      {boot_cfg, boot_ocds, boot_brk, boot_sel} <= {rr_swcfg, rr_ocd, rr_brk, rr_btcfg};
    end else if (seq_done) begin
      {boot_cfg, boot_ocds, boot_brk, boot_sel} <= {hw_cfg, hw_ocd, hw_brk, hw_cfgp};
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);
  chk_trace_off: assert property (!trc_en |=> trace_port == '0)
    else $error("trace active while disabled");
  chk_trace_cop: assert property (trc_en && trc_sel == `SCUTR_SEL_COP |=> trace_port == $past(cop_trace))
    else $error("coprocessor trace not routed");
  chk_trace_rsv: assert property (trc_en && trc_sel[1] |=> trace_port == '0)
    else $error("reserved source drives trace");
  chk_trace_upper: assert property (pready && !pwrite && paddr == `SCUTR_OFF_TRACE |-> prdata[31:3] == 29'h0)
    else $error("trace upper bits not zero");
  chk_maker_read: assert property (pready && !pwrite && paddr == `SCUTR_OFF_MAKER
    |-> prdata == {16'h0000, MAKER_ID, DEPARTMENT_NUMBER_ID})
    else $error("maker id wrong");
  chk_chip_read: assert property (pready && !pwrite && paddr == `SCUTR_OFF_CHIP
    |-> prdata == {16'h0000, PART_ID, REV_ID})
    else $error("chip id wrong");
  chk_redesign_read: assert property (pready && !pwrite && paddr == `SCUTR_OFF_REDESIGN
    |-> prdata[15] == LASER_FIX && prdata[2:0] == REDESIGN_ID)
    else $error("redesign id wrong");
  chk_unmapped_err: assert property (setup && !hit |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_sw_reset: assert property (wr_go && paddr == `SCUTR_OFF_RST_REQ && seq_idle |-> ##2 !seq_rst_b)
    else $error("software reset not started");
  chk_locked_req: assert property (setup && pwrite && paddr == `SCUTR_OFF_RST_REQ && !init_unlock
    |=> pslverr ##1 !sw_req)
    else $error("locked reset request accepted");
  chk_wdt_nmi: assert property ($rose(wd_busy) |-> nmi_req)
    else $error("watchdog NMI missing");
  chk_wdt_timeout: assert property (wdt_req |-> $past(wd_cnt) == WW'(WDT_TIMEOUT_CYC - 1))
    else $error("watchdog timeout count wrong");
  chk_status_cause: assert property (seq_done |=> st_cause == $past(cause))
    else $error("reset cause not recorded");
  chk_pin_drive: assert property ($fell(seq_rst_b) && cause != SCUTR_CAUSE_SFT |=> !bidir_hard_reset_pin_oe_b)
    else $error("reset pin not driven");
  chk_trace_clear: assert property (!seq_rst_b |=> !trc_en && trc_sel == 2'h0)
    else $error("trace not cleared by reset");
  chk_sw_boot: assert property (seq_done && cause == SCUTR_CAUSE_SFT && rr_boot
    |=> boot_cfg == $past(rr_swcfg))
    else $error("software boot not applied");
  cov_sw_reset: cover property (sw_req ##[1:4] !seq_rst_b);
  cov_wdt_reset: cover property (wdt_req ##1 !seq_rst_b);
  cov_wake: cover property (seq_done && cause == SCUTR_CAUSE_PWD);
  cov_cop_trace: cover property (trc_en && trc_sel == `SCUTR_SEL_COP);
endmodule // scutr_top

/* File: include/scutr_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Included by the top and sequencer files of the system control block, and by the bench
// Notes: Definitions only
`ifndef SCUTR_CFG_SVH
`define SCUTR_CFG_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SCUTR_OFF_RST_REQ 8'h10
`define SCUTR_OFF_RST_STAT 8'h14
`define SCUTR_OFF_TRACE 8'h54
`define SCUTR_OFF_MAKER 8'h70
`define SCUTR_OFF_CHIP 8'h74
`define SCUTR_OFF_REDESIGN 8'h78
// ****************************************
// Field positions and encodings
// ****************************************
`define SCUTR_TRC_EN_BIT 0
`define SCUTR_TRC_SEL_LSB 1
`define SCUTR_SEL_CPU 2'h0
`define SCUTR_SEL_COP 2'h1
`define SCUTR_TRC_RESET 3'h0
`define SCUTR_REQ_RESET 13'h0000
// Low three status bits {ext, spare, timer} per reset cause
`define SCUTR_LOW_POR 3'h7
`define SCUTR_LOW_HW 3'h2
`define SCUTR_LOW_WDT 3'h5
`define SCUTR_LOW_WAKE 3'h3
// ****************************************
// Timing counts
// ****************************************
`define SCUTR_RST_HOLD_CYC 16
`define SCUTR_GUARD_CYC 2
`define SCUTR_WDT_TIMEOUT_CYC 512
`endif

/* File: include/scutr_pkg.sv */
// Purpose: Types shared by the system control block
// Assumes: Nothing
// Notes: One-hot codes written out
package scutr_pkg;
  // Reset cause, bit order matches status bits 31..27
  typedef enum logic [4:0] {
    SCUTR_CAUSE_PWO = 5'h01,
    SCUTR_CAUSE_HD = 5'h02,
    SCUTR_CAUSE_SFT = 5'h04,
    SCUTR_CAUSE_WDT = 5'h08,
    SCUTR_CAUSE_PWD = 5'h10
  } scutr_cause_e;
  // Reset sequencer states
  typedef enum logic [2:0] {
    SCUTR_SEQ_IDLE = 3'h1,
    SCUTR_SEQ_HOLD = 3'h2,
    SCUTR_SEQ_GUARD = 3'h4
  } scutr_seq_e;
endpackage

/* File: rtl/scutr_sync.sv */
// Purpose: Two-stage release of the asynchronous reset
// Assumes: Reset active low
// Notes: Assert is asynchronous, release is clocked
`timescale 1ns/1ps
module scutr_sync (
  input wire logic clk,
  input wire logic rst_b,
  output logic rst_sync_b
);
  logic stage1;
  // Shift a one in after release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      rst_sync_b <= stage1;
    end
  end
endmodule // scutr_sync

/* File: rtl/scutr_rst_seq.sv */
// Purpose: Reset sequencer, holds the system in reset and records the cause
// Assumes: Requests are one-cycle pulses or levels in the clk domain
// Notes: Requests are taken only while idle
`timescale 1ns/1ps
`include "scutr_cfg.svh"
module scutr_rst_seq import scutr_pkg::*; #(
  parameter int RST_HOLD_CYC = `SCUTR_RST_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hw_req,
  input wire logic wake_req,
  input wire logic wdt_req,
  input wire logic sw_req,
  input wire logic sw_ext,
  output logic sys_rst_b,
  output logic pin_drive,
  output scutr_cause_e cause,
  output logic done,
  output logic idle
);
  localparam int CW = $clog2(RST_HOLD_CYC + 1);
  scutr_seq_e state;
  logic [CW-1:0] cnt;
  // ****************************************
  // Sequence state machine
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SCUTR_SEQ_HOLD;
      cause <= SCUTR_CAUSE_PWO;
      pin_drive <= 1'b1;
      sys_rst_b <= 1'b0;
      cnt <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        SCUTR_SEQ_IDLE: begin
          cnt <= '0;
          if (hw_req || wake_req || wdt_req || sw_req) begin
            state <= SCUTR_SEQ_HOLD;
            sys_rst_b <= 1'b0;
          end
          if (hw_req) begin
            cause <= SCUTR_CAUSE_HD;
            pin_drive <= 1'b1;
          end else if (wake_req) begin
            cause <= SCUTR_CAUSE_PWD;
            pin_drive <= 1'b1;
          end else if (wdt_req) begin
            cause <= SCUTR_CAUSE_WDT;
            pin_drive <= 1'b1;
          end else if (sw_req) begin
            cause <= SCUTR_CAUSE_SFT;
            pin_drive <= sw_ext;
          end
        end
        SCUTR_SEQ_HOLD: begin
          cnt <= cnt + 1'b1;
          if (cnt == CW'(RST_HOLD_CYC - 1)) begin
            state <= SCUTR_SEQ_GUARD;
            sys_rst_b <= 1'b1;
            pin_drive <= 1'b0;
            done <= 1'b1;
            cnt <= '0;
          end
        end
        SCUTR_SEQ_GUARD: begin
          // Let the pulled-up pin settle before listening again
          cnt <= cnt + 1'b1;
          if (cnt == CW'(`SCUTR_GUARD_CYC - 1)) begin
            state <= SCUTR_SEQ_IDLE;
          end
        end
        default: begin
          state <= SCUTR_SEQ_IDLE;
        end
      endcase
    end
  end
  // Idle flag, registered with the state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle <= 1'b0;
    end else begin
      idle <= (state == SCUTR_SEQ_GUARD && cnt == CW'(`SCUTR_GUARD_CYC - 1))
        || (state == SCUTR_SEQ_IDLE && !(hw_req || wake_req || wdt_req || sw_req));
    end
  end
endmodule // scutr_rst_seq

/* File: test/scutr_far.sv */
// Purpose: Far side model: trace sources and reset pin wire
// Assumes: One clock, sources change every cycle
// Notes: Pin has a weak pull-up
`timescale 1ns/1ps
module scutr_far #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic ext_pull,
  input wire logic bidir_hard_reset_pin_out,
  input wire logic bidir_hard_reset_pin_oe_b,
  output logic bidir_hard_reset_pin_in,
  output logic [W-1:0] cpu_trace,
  output logic [W-1:0] cop_trace
);
  // Open-drain wire: any party pulls low, else pull-up
  assign bidir_hard_reset_pin_in = (ext_pull || (!bidir_hard_reset_pin_oe_b && !bidir_hard_reset_pin_out)) ? 1'h0 : 1'h1;
  // Sources differ and move every cycle, so a stale route shows
  initial begin
    cpu_trace = '0;
    cop_trace = '1;
  end
  always @(posedge clk) begin
    cpu_trace <= cpu_trace + 1'h1;
    cop_trace <= {cpu_trace[W-2:0], ~cpu_trace[W-1]};
  end
endmodule // scutr_far

/* File: test/system_control_trace_id_reset_bench.sv */
// Purpose: Self-checking bench for the system control registers
// Assumes: Zero-wait APB slave, short hold and watchdog counts
// Notes: Seeded random trace settings and boot fields
`timescale 1ns/1ps
`include "scutr_cfg.svh"
module system_control_trace_id_reset_bench;
  // Identification values are arbitrary
  localparam logic [31:0] MK = {16'h0000, 11'h2A5, 5'h0A};
  localparam logic [31:0] CH = {16'h0000, 8'h3C, 8'h07};
  localparam logic [31:0] RD = {16'h0000, 1'h1, 12'h000, 3'h5};
  logic clk, rst_b, psel, penable, pwrite, deep_sleep, init_unlock, wdt_fault, ext_pull, ocds_pin, brk_pin;
  logic pready, pslverr, bidir_hard_reset_pin_out, bidir_hard_reset_pin_oe_b, bidir_hard_reset_pin_in, nmi_req, sys_rst_b, stm_rst_b, boot_ocds, boot_brk;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, w, hs;
  logic [15:0] cpu_trace, cop_trace, trace_port, c, p;
  logic [3:0] cfg_pins, boot_cfg;
  logic [2:0] gp_boot_pins, boot_sel;
  logic err;
  int fails, tests_run, seed, n, i;
  logic [31:0] ids [3];
  logic [7:0] ida [3];

  // Clock, 8 ns period
  always #4 clk = ~clk;

  scutr_top #(.RST_HOLD_CYC(4), .WDT_TIMEOUT_CYC(8),
    .REV_ID(8'h07), .REDESIGN_ID(3'h5), .LASER_FIX(1'h1)) scutr_top_inst (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_trace(cpu_trace), .cop_trace(cop_trace),
    .trace_port(trace_port), .bidir_hard_reset_pin_in(bidir_hard_reset_pin_in), .bidir_hard_reset_pin_out(bidir_hard_reset_pin_out), .bidir_hard_reset_pin_oe_b(bidir_hard_reset_pin_oe_b),
    .deep_sleep(deep_sleep), .init_unlock(init_unlock), .wdt_fault(wdt_fault), .nmi_req(nmi_req),
    .sys_rst_b(sys_rst_b), .stm_rst_b(stm_rst_b), .cfg_pins(cfg_pins), .ocds_pin(ocds_pin),
    .brk_pin(brk_pin), .gp_boot_pins(gp_boot_pins), .boot_cfg(boot_cfg), .boot_ocds(boot_ocds),
    .boot_brk(boot_brk), .boot_sel(boot_sel));

  scutr_far scutr_far_inst (.clk(clk), .ext_pull(ext_pull), .bidir_hard_reset_pin_out(bidir_hard_reset_pin_out),
    .bidir_hard_reset_pin_oe_b(bidir_hard_reset_pin_oe_b), .bidir_hard_reset_pin_in(bidir_hard_reset_pin_in), .cpu_trace(cpu_trace), .cop_trace(cop_trace));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wait_lvl(input logic lvl, input int lim);
    n = 0;
    while (sys_rst_b !== lvl && n < lim) begin
      n++;
      @(posedge clk);
    end
    chk("reset wait", 32'h0, 32'(n >= lim));
  endtask

  // Status word, latched strap fields included
  task automatic stat(input logic [31:0] exp);
    repeat (4) @(posedge clk);
    apb(1'h0, `SCUTR_OFF_RST_STAT, 32'h0);
    chk("status", exp | hs, rd);
  endtask

  // Reset pin pulled low by the far side, awake or asleep
  task automatic pin_reset(input logic sleep, input logic [31:0] exp);
    deep_sleep <= sleep;
    ext_pull <= 1'h1;
    repeat (3) @(posedge clk);
    ext_pull <= 1'h0;
    wait_lvl(1'h0, 20);
    wait_lvl(1'h1, 60);
    deep_sleep <= 1'h0;
    stat(exp);
    chk("boot kept", {v[8:6], v[5], v[4], v[3:0]}, {boot_sel, boot_brk, boot_ocds, boot_cfg});
  endtask

  function automatic logic [15:0] exp_trace(input logic [2:0] r, input logic [15:0] a, input logic [15:0] b);
    if (!r[0]) return 16'h0000;
    return (r[2:1] == `SCUTR_SEL_CPU) ? a : (r[2:1] == `SCUTR_SEL_COP) ? b : 16'h0000;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #150000;
    fails++;
    tally_and_finish();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 1'h0;
    rst_b = 1'h0;
    {psel, penable, pwrite, deep_sleep, init_unlock, wdt_fault, ext_pull} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 90;
    v = $random(seed);
    {gp_boot_pins, brk_pin, ocds_pin, cfg_pins} = v[8:0];
    hs = {11'h000, v[5:4], v[3:0], v[8:6], 12'h000};
    ids = '{MK, CH, RD};
    ida = '{`SCUTR_OFF_MAKER, `SCUTR_OFF_CHIP, `SCUTR_OFF_REDESIGN};
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    wait_lvl(1'h1, 60);
    stat(32'h0800_0007);
    {gp_boot_pins, brk_pin, ocds_pin, cfg_pins} <= ~v[8:0];
    repeat (3) @(posedge clk);
    chk("boot latch", {v[8:6], v[5], v[4], v[3:0]}, {boot_sel, boot_brk, boot_ocds, boot_cfg});
    // Identification reads, refused writes, unmapped place
    for (i = 0; i < 3; i++) begin
      apb(1'h0, ida[i], 32'h0);
      chk("id read", ids[i], rd);
      apb(1'h1, ida[i], 32'hFFFF_FFFF);
      chk("id write err", 32'h1, err);
    end
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, err);
    apb(1'h0, `SCUTR_OFF_TRACE, 32'h0);
    chk("trace reset", 32'h0, rd);
    // Trace routing: every select code, then random settings
    for (i = 0; i < 12; i++) begin
      w = (i < 8) ? i : ($random(seed) & 32'h7);
      apb(1'h1, `SCUTR_OFF_TRACE, w);
      apb(1'h0, `SCUTR_OFF_TRACE, 32'h0);
      chk("trace read", w, rd);
      @(posedge clk);
      c = cpu_trace;
      p = cop_trace;
      @(negedge clk);
      chk("trace port", exp_trace(w[2:0], c, p), trace_port);
    end
    // Reset request while locked is refused
    apb(1'h1, `SCUTR_OFF_RST_REQ, 32'h0000_0005);
    chk("locked err", 32'h1, err);
    repeat (6) @(posedge clk);
    chk("no sw reset", 32'h1, sys_rst_b);
    // Unlocked software reset with its own boot settings
    init_unlock <= 1'h1;
    w = 32'h0100_0005 | ($random(seed) & 32'h001F_F000);
    apb(1'h1, `SCUTR_OFF_RST_REQ, w);
    chk("sw req err", 32'h0, err);
    wait_lvl(1'h0, 10);
    repeat (2) @(negedge clk);
    chk("pin and timer reset", 32'h0, {bidir_hard_reset_pin_in, stm_rst_b, bidir_hard_reset_pin_out});
    wait_lvl(1'h1, 60);
    stat(32'h2000_0005);
    chk("sw boot", w[20:12], {boot_brk, boot_ocds, boot_cfg, boot_sel});
    apb(1'h0, `SCUTR_OFF_TRACE, 32'h0);
    chk("trace cleared", 32'h0, rd);
    // Software reset sparing timer and pin, latched boot kept
    apb(1'h1, `SCUTR_OFF_RST_REQ, 32'h0000_0002);
    chk("sw req err", 32'h0, err);
    wait_lvl(1'h0, 10);
    repeat (2) @(negedge clk);
    chk("pin and timer kept", 32'h6, {bidir_hard_reset_pin_in, stm_rst_b, bidir_hard_reset_pin_out});
    wait_lvl(1'h1, 60);
    stat(32'h2000_0002);
    chk("hw boot", {v[8:6], v[5], v[4], v[3:0]}, {boot_sel, boot_brk, boot_ocds, boot_cfg});
    init_unlock <= 1'h0;
    pin_reset(1'h0, 32'h1000_0002);
    pin_reset(1'h1, 32'h8000_0003);
    // Watchdog: NMI first, reset after the time-out
    wdt_fault <= 1'h1;
    @(posedge clk);
    wdt_fault <= 1'h0;
    @(negedge clk);
    chk("nmi", 32'h3, {nmi_req, sys_rst_b});
    repeat (7) @(negedge clk);
    chk("wdt grace", 32'h1, sys_rst_b);
    wait_lvl(1'h0, 40);
    wait_lvl(1'h1, 60);
    stat(32'h4000_0005);
    tally_and_finish();
  end
endmodule // system_control_trace_id_reset_bench
